// >>> design/fail_safe_clock_map.svh
// Register offsets, field positions, reset values and timing counts
`ifndef FAIL_SAFE_CLOCK_MAP_SVH
`define FAIL_SAFE_CLOCK_MAP_SVH
`define CLOCK_REQUEST_OFFSET 12'h88d
`define CLOCK_CURRENT_OFFSET 12'h88e
`define CLOCK_SWITCH_CONTROL_OFFSET 12'h88f
`define OSC_READY_FLAGS_OFFSET 12'h890
`define OSC_FORCE_ON_OFFSET 12'h891
`define INTERNAL_OSC_TRIM_OFFSET 12'h892
`define INTERNAL_OSC_FREQ_SELECT_OFFSET 12'h893
`define FAIL_STATUS_OFFSET 12'h894
`define HOLD_BIT 7
`define SECONDARY_POWER_BIT 6
`define DONE_BIT 4
`define NEW_READY_BIT 3
`define FLAG_FAIL_BIT 0
`define FLAG_SWITCH_BIT 1
`define FLAG_FAIL_IE_BIT 2
`define SRC_EXTERNAL 3'h7
`define SRC_HIGH_INTERNAL 3'h6
`define SRC_LOW_INTERNAL 3'h5
`define SRC_SECONDARY 3'h4
`define SRC_RESERVED_HI 3'h3
`define SRC_EXTERNAL_PLL 3'h2
`define SRC_HIGH_PLL 3'h1
`define SRC_RESERVED_LO 3'h0
`define DIV_MAX 4'h9
`define DIV_HIGH_RESET 4'h2
`define DIV_OTHER_RESET 4'h0
`define DIV_FAILSAFE_1MHZ 4'h2
`define SAMPLE_DIVIDE 64
`define SAMPLE_HALF 6'h1f
`define STARTUP_TIME_CYCLES 1024
`endif

// >>> design/fail_safe_clock_pkg.sv
// Types shared by the fail-safe clock switch
package fail_safe_clock_pkg;
   typedef enum logic [1:0] {
      sw_idle = 2'b00,
      sw_wait = 2'b01,
      sw_ready = 2'b10
   } switch_state_t;

   typedef struct packed {
      logic [2:0] source;
      logic [3:0] divider;
   } clock_sel_t;

   typedef struct packed {
      logic [11:0] addr;
      logic [7:0] wdata;
      logic write;
      logic read;
   } reg_req_t;
endpackage

// >>> design/fail_safe_clock_switch.sv
// Fail-safe clock monitor and system clock source/divider switch
//
// How it works
// - monitor runs only when enabled, all external modes
// - sample clock is low oscillator divided 64
// - latch set by external fall, cleared sample rise
// - fail when half sample period lacks external fall
// - failure forces high internal 1 MHz, sets flag
// - interrupt only when fail flag and enable set
// - stay internal until new request switches back
// - sleep, reset or request change clears fail condition
// - external return restarts startup timer, run internal
// - persisting failure sets fail flag again
// - startup timer after reset/wake, not clock-input mode
// - switch flag never cleared by hardware
// - done reads zero when request differs current
// - source codes fixed, 011 and 000 reserved
// - divider is two to code, above 1001 reserved
// - reserved source write is ignored entirely
// - permit zero makes request register read-only
// - request reset from strap; divider depends source
// - current fields read-only, reset to request
// - hold stops switch when new source ready
// - completion updates current, sets done, clears ready
`timescale 1ns/100ps
`include "fail_safe_clock_map.svh"
module fail_safe_clock_switch (
   input wire logic clock,
   input wire logic resetn,
   input wire logic [11:0] addr,
   input wire logic [7:0] wdata,
   input wire logic write,
   input wire logic read,
   output logic [7:0] rdata,
   input wire logic external_clk,
   input wire logic low_freq_internal_osc,
   input wire logic fail_safe_enable_cfg,
   input wire logic switch_permit_cfg,
   input wire logic [2:0] reset_source_cfg,
   input wire logic external_clock_input_mode,
   input wire logic sleep_enter,
   input wire logic wake_up,
   input wire logic [7:0] osc_ready_pins,
   output fail_safe_clock_pkg::clock_sel_t system_clock_sel,
   output logic osc_fail_irq,
   output logic switch_irq_flag,
   output logic [7:0] osc_force_on,
   output logic [7:0] osc_trim,
   output logic [7:0] osc_freq_select
);
   // ***************************
   // Failure detector (oscillator domains)
   // ***************************
   logic [5:0] sample_count;
   logic sample_clk;
   logic detect_latch;
   logic sample_meta;
   logic sample_fail;

   always_ff @(posedge low_freq_internal_osc or negedge resetn) begin
      if (!resetn) begin
         sample_count <= 6'h00;
      end else begin
         sample_count <= sample_count + 6'h01;
      end
   end
   assign sample_clk = sample_count[5];

   // Set-dominant latch modelled as two edge domains would double-drive; use a
   // toggle-free sticky: set on external fall, sample rise consumes it.
   logic ext_seen;
   logic ext_seen_ack;
   always_ff @(negedge external_clk or negedge resetn) begin
      if (!resetn) begin
         ext_seen <= 1'b0;
      end else begin
         ext_seen <= ~ext_seen_ack;
      end
   end

   always_ff @(posedge sample_clk or negedge resetn) begin
      if (!resetn) begin
         ext_seen_ack <= 1'b0;
      end else begin
         ext_seen_ack <= ext_seen;
      end
   end

   // Judged on the fall: a whole period would let a dead crystal hide twice as long
   always_ff @(negedge sample_clk or negedge resetn) begin
      if (!resetn) begin
         detect_latch <= 1'b0;
      end else begin
         // No external fall since the last rise: a full half period passed
         detect_latch <= (ext_seen == ext_seen_ack);
      end
   end

   always_ff @(posedge low_freq_internal_osc or negedge resetn) begin
      if (!resetn) begin
         sample_meta <= 1'b0;
         sample_fail <= 1'b0;
      end else begin
         sample_meta <= detect_latch;
         sample_fail <= sample_meta;
      end
   end

   // ***************************
   // System clock domain state
   // ***************************
   typedef struct packed {
      logic fail_meta;
      logic fail_sync;
      logic [7:0] ready_meta;
      logic [7:0] ready_sync;
      logic strap_done;
      fail_safe_clock_pkg::clock_sel_t request;
      fail_safe_clock_pkg::clock_sel_t current;
      fail_safe_clock_pkg::switch_state_t sw_state;
      logic hold;
      logic sec_power;
      logic new_ready;
      logic fail_flag;
      logic fail_ie;
      logic switch_flag;
      logic fail_active;
      logic [10:0] timer;
      logic timer_run;
      logic [7:0] force_on;
      logic [7:0] trim;
      logic [7:0] freq;
      logic [7:0] rdata;
   } state_t;

   state_t s;
   state_t next_s;

   function automatic logic [3:0] reset_divider(input logic [2:0] src);
      reset_divider = (src == `SRC_HIGH_INTERNAL) ? `DIV_HIGH_RESET : `DIV_OTHER_RESET;
   endfunction

   function automatic logic source_ready(input logic [2:0] src, input logic [7:0] rdy);
      case (src)
         `SRC_EXTERNAL: source_ready = rdy[7];
         `SRC_HIGH_INTERNAL: source_ready = rdy[6];
         `SRC_LOW_INTERNAL: source_ready = rdy[4];
         `SRC_SECONDARY: source_ready = rdy[3];
         `SRC_EXTERNAL_PLL: source_ready = rdy[7] & rdy[0];
         `SRC_HIGH_PLL: source_ready = rdy[6] & rdy[0];
         default: source_ready = 1'b0;
      endcase
   endfunction

   logic is_external;
   logic monitor_on;
   logic req_write;
   logic done;
   logic [7:0] ctrl_read;
   logic fail_now;
   logic sw_set;

   always_comb begin
      next_s = s;
      next_s.fail_meta = sample_fail;
      next_s.fail_sync = s.fail_meta;
      next_s.ready_meta = osc_ready_pins;
      next_s.ready_sync = s.ready_meta;
      is_external = (s.current.source == `SRC_EXTERNAL) ||
         (s.current.source == `SRC_EXTERNAL_PLL) || (s.current.source == `SRC_SECONDARY);
      monitor_on = fail_safe_enable_cfg && is_external && !s.timer_run;
      fail_now = monitor_on && s.fail_sync && !s.fail_active;
      sw_set = 1'b0;
      done = (s.request == s.current);
      req_write = write && (addr == `CLOCK_REQUEST_OFFSET) && switch_permit_cfg &&
         (wdata[6:4] != `SRC_RESERVED_HI) && (wdata[6:4] != `SRC_RESERVED_LO) &&
         (wdata[3:0] <= `DIV_MAX);
      ctrl_read = 8'h00;
      ctrl_read[`HOLD_BIT] = s.hold;
      ctrl_read[`SECONDARY_POWER_BIT] = s.sec_power;
      ctrl_read[`DONE_BIT] = done;
      ctrl_read[`NEW_READY_BIT] = s.new_ready;

      // Strap captured after reset release, never under the async reset
      if (!s.strap_done) begin
         next_s.strap_done = 1'b1;
         next_s.request.source = reset_source_cfg;
         next_s.request.divider = reset_divider(reset_source_cfg);
         next_s.current.source = reset_source_cfg;
         next_s.current.divider = reset_divider(reset_source_cfg);
         next_s.timer_run = !external_clock_input_mode;
         next_s.timer = 11'h000;
      end

      // Startup timer
      if (s.timer_run) begin
         next_s.timer = s.timer + 11'h001;
         if (s.timer == 11'(`STARTUP_TIME_CYCLES - 1)) begin
            next_s.timer_run = 1'b0;
         end
      end

      // Wake-up reapplies startup timer
      if (wake_up && !external_clock_input_mode) begin
         next_s.timer_run = 1'b1;
         next_s.timer = 11'h000;
      end

      // Switch sequence
      case (s.sw_state)
         fail_safe_clock_pkg::sw_idle: begin
            if (!done && s.strap_done && !s.fail_active) begin
               next_s.sw_state = fail_safe_clock_pkg::sw_wait;
            end
         end
         fail_safe_clock_pkg::sw_wait: begin
            if (done) begin
               next_s.sw_state = fail_safe_clock_pkg::sw_idle;
            end else if (source_ready(s.request.source, s.ready_sync) && !s.timer_run) begin
               next_s.new_ready = 1'b1;
               sw_set = 1'b1;
               next_s.sw_state = fail_safe_clock_pkg::sw_ready;
            end
         end
         fail_safe_clock_pkg::sw_ready: begin
            if (done) begin
               next_s.new_ready = 1'b0;
               next_s.sw_state = fail_safe_clock_pkg::sw_idle;
            end else if (!s.hold) begin
               next_s.current = s.request;
               next_s.new_ready = 1'b0;
               next_s.fail_active = 1'b0;
               next_s.sw_state = fail_safe_clock_pkg::sw_idle;
            end
         end
         default: next_s.sw_state = fail_safe_clock_pkg::sw_idle;
      endcase

      // Register writes
      if (write) begin
         case (addr)
            `CLOCK_SWITCH_CONTROL_OFFSET: begin
               next_s.hold = wdata[`HOLD_BIT];
               next_s.sec_power = wdata[`SECONDARY_POWER_BIT];
            end
            `OSC_FORCE_ON_OFFSET: next_s.force_on = {wdata[7:2], 2'b00};
            `INTERNAL_OSC_TRIM_OFFSET: next_s.trim = {2'b00, wdata[5:0]};
            `INTERNAL_OSC_FREQ_SELECT_OFFSET: next_s.freq = {5'h00, wdata[2:0]};
            `FAIL_STATUS_OFFSET: begin
               // Software clears with zero; hardware set below still wins
               if (!wdata[`FLAG_FAIL_BIT]) next_s.fail_flag = 1'b0;
               if (!wdata[`FLAG_SWITCH_BIT]) next_s.switch_flag = 1'b0;
               next_s.fail_ie = wdata[`FLAG_FAIL_IE_BIT];
            end
            default: ;
         endcase
      end
      // Hardware set beats a software clear in the same cycle
      if (sw_set) next_s.switch_flag = 1'b1;

      // Any accepted request write re-arms the return from fail-safe
      if (req_write) begin
         next_s.request = {wdata[6:4], wdata[3:0]};
         next_s.fail_active = 1'b0;
         if ((wdata[6:4] == `SRC_EXTERNAL) || (wdata[6:4] == `SRC_EXTERNAL_PLL)) begin
            next_s.timer_run = !external_clock_input_mode;
            next_s.timer = 11'h000;
         end
      end

      if (sleep_enter) begin
         next_s.fail_active = 1'b0;
      end

      // Failure: force high internal at 1 MHz, set flag (set beats clear)
      if (fail_now) begin
         next_s.fail_active = 1'b1;
         next_s.fail_flag = 1'b1;
         next_s.current.source = `SRC_HIGH_INTERNAL;
         next_s.current.divider = `DIV_FAILSAFE_1MHZ;
         next_s.new_ready = 1'b0;
         next_s.sw_state = fail_safe_clock_pkg::sw_idle;
      end

      // Read data, one cycle later
      next_s.rdata = 8'h00;
      if (read) begin
         case (addr)
            `CLOCK_REQUEST_OFFSET: next_s.rdata = {1'b0, s.request.source, s.request.divider};
            `CLOCK_CURRENT_OFFSET: next_s.rdata = {1'b0, s.current.source, s.current.divider};
            `CLOCK_SWITCH_CONTROL_OFFSET: next_s.rdata = ctrl_read;
            `OSC_READY_FLAGS_OFFSET: next_s.rdata = {s.ready_sync[7:2], 1'b0, s.ready_sync[0]};
            `OSC_FORCE_ON_OFFSET: next_s.rdata = s.force_on;
            `INTERNAL_OSC_TRIM_OFFSET: next_s.rdata = s.trim;
            `INTERNAL_OSC_FREQ_SELECT_OFFSET: next_s.rdata = s.freq;
            `FAIL_STATUS_OFFSET: next_s.rdata = {5'h00, s.fail_ie, s.switch_flag, s.fail_flag};
            default: next_s.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign rdata = s.rdata;
   assign system_clock_sel = s.current;
   assign osc_fail_irq = s.fail_flag && s.fail_ie;
   assign switch_irq_flag = s.switch_flag;
   assign osc_force_on = s.force_on;
   assign osc_trim = s.trim;
   assign osc_freq_select = s.freq;

   // ***************************
   // Assertions
   // ***************************
   sequence fail_seen;
      fail_now;
   endsequence

   sequence switch_armed;
      (s.sw_state == fail_safe_clock_pkg::sw_wait) ##1
      (s.sw_state == fail_safe_clock_pkg::sw_ready);
   endsequence

   AST_FAIL_FORCES_INTERNAL: assert property (@(posedge clock) disable iff (!resetn)
      fail_seen |=> (s.current.source == `SRC_HIGH_INTERNAL) && s.fail_flag)
      else $error("failure did not force internal source");
   AST_IRQ_GATED: assert property (@(posedge clock) disable iff (!resetn)
      osc_fail_irq == (s.fail_flag && s.fail_ie))
      else $error("fail interrupt not gated by enable");
   AST_NO_MONITOR_DISABLED: assert property (@(posedge clock) disable iff (!resetn)
      !fail_safe_enable_cfg |=> !$rose(s.fail_active))
      else $error("monitor acted while disabled");
   AST_SWITCH_FLAG_STICKY: assert property (@(posedge clock) disable iff (!resetn)
      s.switch_flag && !(write && addr == `FAIL_STATUS_OFFSET) |=> s.switch_flag)
      else $error("switch flag cleared by hardware");
   AST_HOLD_BLOCKS: assert property (@(posedge clock) disable iff (!resetn)
      (s.sw_state == fail_safe_clock_pkg::sw_ready) && s.hold && !fail_now
      |=> $stable(s.current))
      else $error("switch completed during hold");
   AST_COMPLETE: assert property (@(posedge clock) disable iff (!resetn)
      (s.sw_state == fail_safe_clock_pkg::sw_ready) && !s.hold && !done && !fail_now
      |=> done && !s.new_ready)
      else $error("switch completion incorrect");
   AST_RESERVED_IGNORED: assert property (@(posedge clock) disable iff (!resetn)
      write && addr == `CLOCK_REQUEST_OFFSET && wdata[6:4] == `SRC_RESERVED_LO && s.strap_done
      |=> $stable(s.request))
      else $error("reserved source written");
   AST_PERMIT_LOCK: assert property (@(posedge clock) disable iff (!resetn)
      !switch_permit_cfg && s.strap_done |=> $stable(s.request))
      else $error("request changed without permit");
   AST_TIMER_GATES: assert property (@(posedge clock) disable iff (!resetn)
      s.timer_run && s.sw_state == fail_safe_clock_pkg::sw_wait
      |=> s.sw_state != fail_safe_clock_pkg::sw_ready)
      else $error("switch ready while startup timer running");
   AST_READY_RAISES: assert property (@(posedge clock) disable iff (!resetn)
      switch_armed |-> s.new_ready && s.switch_flag)
      else $error("new source ready without ready bit or flag");
   AST_SWITCH_STARTS: assert property (@(posedge clock) disable iff (!resetn)
      (s.sw_state == fail_safe_clock_pkg::sw_idle) && s.strap_done && !done &&
      !s.fail_active && !fail_now |=> s.sw_state == fail_safe_clock_pkg::sw_wait)
      else $error("switch did not begin on mismatch");
   AST_FAIL_KEEPS_INTERNAL: assert property (@(posedge clock) disable iff (!resetn)
      s.fail_active && !req_write |=> $stable(s.current))
      else $error("left fail-safe source without a request write");
   AST_REQUEST_CLEARS: assert property (@(posedge clock) disable iff (!resetn)
      req_write && !fail_now |=> !s.fail_active)
      else $error("request write did not clear fail-safe");
   AST_DIV_RESERVED: assert property (@(posedge clock) disable iff (!resetn)
      write && addr == `CLOCK_REQUEST_OFFSET && wdata[3:0] > `DIV_MAX && s.strap_done
      |=> $stable(s.request))
      else $error("reserved divider written");
   AST_STRAP_LOAD: assert property (@(posedge clock) disable iff (!resetn)
      !s.strap_done |=> (s.request.source == $past(reset_source_cfg)) &&
      (s.request.divider == (($past(reset_source_cfg) == `SRC_HIGH_INTERNAL) ?
      `DIV_HIGH_RESET : `DIV_OTHER_RESET)))
      else $error("request not loaded from strap");
   AST_CURRENT_RESET: assert property (@(posedge clock) disable iff (!resetn)
      !s.strap_done |=> s.current == s.request)
      else $error("current selection not reset to request");
endmodule

// >>> testbench/ext_osc_model.sv
// External oscillator model: free-running clock that can be made to fail
`timescale 1ns/100ps
module ext_osc_model #(
   parameter int HALF_NS = 50
) (
   input wire logic run,
   output logic osc_clk
);
   // ****************
   // Oscillator
   // ****************
   // A dead crystal parks high, so no falling edge reaches the detector
   initial begin
      osc_clk = 1'b1;
      forever begin
         #HALF_NS;
         if (run) begin
            osc_clk = ~osc_clk;
         end else begin
            osc_clk = 1'b1;
         end
      end
   end
endmodule

// >>> testbench/fail_safe_clock_switch_tb.sv
// Self-checking bench for the fail-safe clock switch
`timescale 1ns/100ps
`define CHECK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_fail++; \
   $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module fail_safe_clock_switch_tb;
   logic clock, resetn, write, read, low_osc, ext_run, permit, ext_clk, fail_irq, sw_flag;
   logic [11:0] addr;
   logic [7:0] wdata, rdata, r;
   logic [2:0] strap;
   logic fcm_en;
   fail_safe_clock_pkg::clock_sel_t sel;
   int n_fail = 0;
   int tests_run = 0;

   ext_osc_model ext_osc_model_i (.run(ext_run), .osc_clk(ext_clk));
   fail_safe_clock_switch fail_safe_clock_switch_i (.clock(clock), .resetn(resetn),
      .addr(addr), .wdata(wdata), .write(write), .read(read), .rdata(rdata),
      .external_clk(ext_clk), .low_freq_internal_osc(low_osc),
      .fail_safe_enable_cfg(fcm_en), .switch_permit_cfg(permit), .reset_source_cfg(strap),
      .external_clock_input_mode(1'b0), .sleep_enter(1'b0), .wake_up(1'b0),
      .osc_ready_pins(8'hd9), .system_clock_sel(sel), .osc_fail_irq(fail_irq),
      .switch_irq_flag(sw_flag), .osc_force_on(), .osc_trim(), .osc_freq_select());

   // ****************
   // Clocks and bus
   // ****************
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Sample clock source kept fast so a failure shows within a few hundred cycles
   initial begin
      low_osc = 1'b0;
      forever #40 low_osc = ~low_osc;
   end

   task automatic print_verdict();
      if (n_fail == 0 && tests_run > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   task automatic do_reset(input logic [2:0] s, input logic p);
      @(posedge clock);
      resetn <= 1'b0;
      strap <= s;
      permit <= p;
      repeat (2) @(posedge clock);
      resetn <= 1'b1;
      repeat (2) @(posedge clock);
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      wdata <= d;
      write <= 1'b1;
      @(posedge clock);
      write <= 1'b0;
   endtask

   task automatic rd(input logic [11:0] a);
      @(posedge clock);
      addr <= a;
      read <= 1'b1;
      @(posedge clock);
      read <= 1'b0;
      @(negedge clock);
      r = rdata;
   endtask

   // Polls a register; running out of tries ends the run
   task automatic wait_reg(input logic [11:0] a, input logic [7:0] m, input logic [7:0] e,
                           input int bound);
      int i;
      rd(a);
      for (i = 0; i < bound && (r & m) !== e; i++) begin
         rd(a);
      end
      `CHECK(r & m, e)
      if ((r & m) !== e) begin
         print_verdict();
      end
   endtask

   // ****************
   // Scenarios
   // ****************
   task automatic t_reset_permit();
      do_reset(3'h5, 1'b0);
      rd(12'h88d); `CHECK(r, 8'h50)
      wr(12'h88d, 8'h60);
      rd(12'h88d); `CHECK(r, 8'h50)
      wr(12'h88e, 8'h11);
      rd(12'h88e); `CHECK(r, 8'h50)
      do_reset(3'h6, 1'b1);
      rd(12'h88d); `CHECK(r, 8'h62)
      rd(12'h88e); `CHECK(r, 8'h62)
      rd(12'h88f); `CHECK(r, 8'h10)
      `CHECK(sel, 7'h62)
   endtask

   task automatic t_codes_hold();
      logic [7:0] e;
      e = 8'h62;
      wr(12'h88f, 8'h80);
      for (int c = 0; c < 8; c++) begin
         if (c != 0 && c != 3) begin
            e = {1'b0, c[2:0], 4'h0};
         end
         wr(12'h88d, {1'b0, c[2:0], 4'h0});
         rd(12'h88d); `CHECK(r, e)
      end
      wr(12'h88d, 8'h59);
      rd(12'h88d); `CHECK(r, 8'h59)
      wr(12'h88d, 8'h5a);
      rd(12'h88d); `CHECK(r, 8'h59)
      wait_reg(12'h88f, 8'h18, 8'h08, 700);
      rd(12'h88f); `CHECK(r[4], 1'b0)
      `CHECK(sel, 7'h62)
      wr(12'h88f, 8'h00);
      wait_reg(12'h88e, 8'hff, 8'h59, 50);
      rd(12'h88f); `CHECK(r[4:3], 2'b10)
      repeat (50) @(posedge clock);
      `CHECK(sw_flag, 1'b1)
      wr(12'h894, 8'h00);
      @(posedge clock);
      `CHECK(sw_flag, 1'b0)
   endtask

   task automatic t_failsafe();
      wr(12'h894, 8'h04);
      wr(12'h88d, 8'h70);
      repeat (500) @(posedge clock);
      `CHECK(sel, 7'h59)
      wait_reg(12'h88e, 8'hff, 8'h70, 700);
      ext_run <= 1'b0;
      wait_reg(12'h88e, 8'hff, 8'h62, 1500);
      rd(12'h894); `CHECK(r[0], 1'b1)
      `CHECK(fail_irq, 1'b1)
      wr(12'h894, 8'h00);
      wr(12'h88d, 8'h70);
      wait_reg(12'h894, 8'h01, 8'h01, 1500);
      `CHECK(fail_irq, 1'b0)
      `CHECK(sel, 7'h62)
      ext_run <= 1'b1;
      wr(12'h894, 8'h00);
      wr(12'h88d, 8'h71);
      wait_reg(12'h88e, 8'hff, 8'h71, 1500);
      @(posedge clock);
      fcm_en <= 1'b0;
      ext_run <= 1'b0;
      repeat (400) @(posedge clock);
      `CHECK(sel, 7'h71)
      rd(12'h894); `CHECK(r[0], 1'b0)
   endtask

   initial begin
      resetn = 1'b0;
      write = 1'b0;
      read = 1'b0;
      addr = 12'h000;
      wdata = 8'h00;
      strap = 3'h6;
      permit = 1'b1;
      ext_run = 1'b1;
      fcm_en = 1'b1;
      t_reset_permit();
      t_codes_hold();
      t_failsafe();
      print_verdict();
   end
endmodule
